// ---- ufis_top.sv ----
`timescale 1ns/100ps
module ufis_top
    import ufis_pkg::*;
#(
    parameter int DEPTH = UFIS_DEPTH,
    parameter int LW    = $clog2(DEPTH + 1)
) (
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [4:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic [31:0]        wb_dat_o,
    output logic               wb_ack_o,
    input  wire ufis_evt_t     evt,
    output logic               tx_dma_ready_n,
    output logic               rx_dma_ready_n,
    output logic               fifo_en_o,
    output logic               tx_flush_o,
    output logic               rx_flush_o
);

    // Thresholds must fit inside the fifo
    if (DEPTH < UFIS_TXTRG_3 + 2) begin : g_depth_chk
        $error("ufis_top: DEPTH too small for trigger levels");
    end

    // Level fields of the levels register are eight bits wide
    if (LW > 8 || LW < $clog2(DEPTH + 1)) begin : g_width_chk
        $error("ufis_top: LW does not suit DEPTH");
    end

    // Trigger decode for the receive side
    function automatic logic [LW-1:0] rx_trig(input logic [1:0] code);
        unique case (code)
            2'h0: rx_trig = LW'(UFIS_RXTRG_0);
            2'h1: rx_trig = LW'(UFIS_RXTRG_1);
            2'h2: rx_trig = LW'(UFIS_RXTRG_2);
            2'h3: rx_trig = LW'(UFIS_RXTRG_3);
        endcase
    endfunction

    // Trigger decode for the transmit side
    function automatic logic [LW-1:0] tx_trig(input logic [1:0] code);
        unique case (code)
            2'h0: tx_trig = LW'(UFIS_TXTRG_0);
            2'h1: tx_trig = LW'(UFIS_TXTRG_1);
            2'h2: tx_trig = LW'(UFIS_TXTRG_2);
            2'h3: tx_trig = LW'(UFIS_TXTRG_3);
        endcase
    endfunction

    logic [7:0]    fifo_control_reg;     // Enable, dma mode, triggers
    logic [5:0]    int_enable_reg;       // Per-source enables
    logic [7:0]    enhanced_feature_reg; // Bit 4 gates levels 5 and 6
    logic          tx_flush_reg;         // One-cycle flush strobes
    logic          rx_flush_reg;
    logic          ack_reg;
    logic [31:0]   dat_reg;
    logic          tx_rdy_n_reg;
    logic          rx_rdy_n_reg;
    logic          line_pend_reg;        // Sticky sources
    logic          to_pend_reg;
    logic          thre_pend_reg;
    logic          modem_pend_reg;
    logic          xoff_pend_reg;
    logic          flow_pend_reg;
    logic          thre_seen_reg;        // Previous tx-empty-and-enabled level

    logic          req;                  // New bus request this cycle
    logic          wr;
    logic          rd;
    logic          fcr_wr;
    logic          isr_rd;
    logic          fen;
    logic          dma1;
    logic          enh;
    logic [LW-1:0] rx_level;
    logic [LW-1:0] tx_level;
    logic          rx_empty;
    logic          tx_full;
    logic          tx_empty;
    logic [LW-1:0] rx_trg;
    logic [LW-1:0] tx_trg;
    logic          rx_at_trg;
    logic          thre_cond;
    logic [5:0]    isr_code;
    logic [7:0]    isr_byte;

    // Request decode; ack_reg blocks a second take of the same request
    // Reads ignore the byte lanes; writes need lane 0
    assign req    = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr     = req && wb_we_i && wb_sel_i[0];
    assign rd     = req && !wb_we_i;
    assign fcr_wr = wr && (wb_adr_i == UFIS_OFS_FCR);
    assign isr_rd = rd && (wb_adr_i == UFIS_OFS_ISR);

    assign fen  = fifo_control_reg[UFIS_FCR_EN];
    assign dma1 = fen && fifo_control_reg[UFIS_FCR_DMA];
    assign enh  = enhanced_feature_reg[UFIS_EFR_ENH];

    assign rx_trg = rx_trig(fifo_control_reg[UFIS_FCR_RXTRG_LO +: 2]);
    assign tx_trg = tx_trig(fifo_control_reg[UFIS_FCR_TXTRG_LO +: 2]);

    // Without fifos one byte in the holding register counts as trigger
    assign rx_at_trg = fen ? (rx_level >= rx_trg) : !rx_empty;
    assign thre_cond = tx_empty && int_enable_reg[UFIS_IEN_THRE];

    // Occupancy of the two fifos
    ufis_fifo_level #(.DEPTH(DEPTH), .LW(LW)) u_rx_lvl (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .ce     (ce),
        .flush  (rx_flush_reg),
        .single (!fen),
        .push   (evt.rx_push),
        .pop    (evt.rx_pop),
        .level  (rx_level),
        .full   (),
        .empty  (rx_empty)
    );

    ufis_fifo_level #(.DEPTH(DEPTH), .LW(LW)) u_tx_lvl (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .ce     (ce),
        .flush  (tx_flush_reg),
        .single (!fen),
        .push   (evt.tx_push),
        .pop    (evt.tx_pop),
        .level  (tx_level),
        .full   (tx_full),
        .empty  (tx_empty)
    );

    // Fifo control: a write with enable low only turns fifos off
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fifo_control_reg <= UFIS_FCR_RST;
        end else if (ce && fcr_wr) begin
            if (wb_dat_i[UFIS_FCR_EN]) begin
                fifo_control_reg <= {wb_dat_i[7:3], 3'h1};
            end else begin
                fifo_control_reg[UFIS_FCR_EN] <= 1'b0;
            end
        end
    end

    // Flush strobes; also fired on any change of the enable bit
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_flush_reg <= 1'b0;
            rx_flush_reg <= 1'b0;
        end else if (ce) begin
            tx_flush_reg <= 1'b0;
            rx_flush_reg <= 1'b0;
            if (fcr_wr) begin
                // Toggling the enable empties both so stale counts cannot leak
                if (wb_dat_i[UFIS_FCR_EN] != fen) begin
                    tx_flush_reg <= 1'b1;
                    rx_flush_reg <= 1'b1;
                end
                if (wb_dat_i[UFIS_FCR_EN] && wb_dat_i[UFIS_FCR_TXFLUSH]) begin
                    tx_flush_reg <= 1'b1;
                end
                if (wb_dat_i[UFIS_FCR_EN] && wb_dat_i[UFIS_FCR_RXFLUSH]) begin
                    rx_flush_reg <= 1'b1;
                end
            end
        end
    end

    // Software-owned enable registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            int_enable_reg       <= UFIS_IEN_RST;
            enhanced_feature_reg <= UFIS_EFR_RST;
        end else if (ce && wr) begin
            if (wb_adr_i == UFIS_OFS_IEN) begin
                int_enable_reg <= wb_dat_i[5:0];
            end
            if (wb_adr_i == UFIS_OFS_EFR) begin
                enhanced_feature_reg <= wb_dat_i[7:0];
            end
        end
    end

    // Sticky sources; in every case the set wins over a same-cycle clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            line_pend_reg  <= 1'b0;
            to_pend_reg    <= 1'b0;
            modem_pend_reg <= 1'b0;
            xoff_pend_reg  <= 1'b0;
            flow_pend_reg  <= 1'b0;
        end else if (ce) begin
            line_pend_reg  <= evt.line_evt ||
                              (line_pend_reg && !evt.line_clr);
            // Timeout exists only with fifos; drained by a read or flush
            to_pend_reg    <= (fen && evt.timeout_evt) ||
                              (to_pend_reg && fen && !evt.rx_pop && !rx_flush_reg);
            modem_pend_reg <= evt.modem_evt ||
                              (modem_pend_reg && !evt.modem_clr);
            xoff_pend_reg  <= evt.xoff_evt ||
                              (xoff_pend_reg && !evt.xon_evt);
            // Flow change is acknowledged by reading its own status code
            flow_pend_reg  <= evt.flow_evt ||
                              (flow_pend_reg &&
                               !(isr_rd && isr_code == UFIS_ISR_FLOW));
        end
    end

    // Tx empty: set when empty-and-enabled begins, cleared by a write or a status read that shows it
    // Edge detect keeps a read-cleared empty from firing again at once
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            thre_pend_reg <= 1'b0;
            thre_seen_reg <= 1'b0;
        end else if (ce) begin
            thre_seen_reg <= thre_cond;
            if (thre_cond && !thre_seen_reg) begin
                thre_pend_reg <= 1'b1;
            end else if (evt.tx_push ||
                         (isr_rd && isr_code == UFIS_ISR_THRE)) begin
                thre_pend_reg <= 1'b0;
            end
        end
    end

    // Fixed priority encoder, level 1 first, recomputed every cycle
    // Level 2 timeout shares the rx data enable bit
    always_comb begin
        isr_code = UFIS_ISR_NONE;
        if (line_pend_reg && int_enable_reg[UFIS_IEN_LINE]) begin
            isr_code = UFIS_ISR_LINE;
        end else if (rx_at_trg && int_enable_reg[UFIS_IEN_RXDATA]) begin
            isr_code = UFIS_ISR_RXDAT;
        end else if (to_pend_reg && int_enable_reg[UFIS_IEN_RXDATA]) begin
            isr_code = UFIS_ISR_RXTO;
        end else if (thre_pend_reg) begin
            isr_code = UFIS_ISR_THRE;
        end else if (modem_pend_reg && int_enable_reg[UFIS_IEN_MODEM]) begin
            isr_code = UFIS_ISR_MODEM;
        end else if (enh && xoff_pend_reg && int_enable_reg[UFIS_IEN_XOFF]) begin
            isr_code = UFIS_ISR_XOFF;
        end else if (enh && flow_pend_reg && int_enable_reg[UFIS_IEN_FLOW]) begin
            isr_code = UFIS_ISR_FLOW;
        end
    end

    // Fifo mode flag sits in the top two bits
    assign isr_byte = {{2{fen}}, isr_code};

    // Wishbone answer: one registered ack, dropped the next cycle
    // Status is latched at the taking edge, so clear-on-read hits what was shown
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else if (ce) begin
            ack_reg <= req;
            if (rd) begin
                unique case (wb_adr_i)
                    UFIS_OFS_ISR: dat_reg <= {24'h00_0000, isr_byte};
                    UFIS_OFS_IEN: dat_reg <= {26'h000_0000, int_enable_reg};
                    UFIS_OFS_EFR: dat_reg <= {24'h00_0000, enhanced_feature_reg};
                    UFIS_OFS_LVL: dat_reg <= {14'h0000, rx_rdy_n_reg, tx_rdy_n_reg,
                                              (8 - LW)'(0), tx_level,
                                              (8 - LW)'(0), rx_level};
                    // Write-only control and unmapped offsets read zero
                    default:      dat_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Transmit DMA ready, active low
    // Holds between trigger and full so the DMA moves whole blocks
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_rdy_n_reg <= 1'b0;
        end else if (ce) begin
            if (dma1) begin
                if (tx_full) begin
                    tx_rdy_n_reg <= 1'b1;
                end else if (tx_level <= tx_trg) begin
                    tx_rdy_n_reg <= 1'b0;
                end
            end else begin
                // Single-transfer mode: ready only while nothing is queued
                tx_rdy_n_reg <= !tx_empty;
            end
        end
    end

    // Receive DMA ready, active low
    // Once low it stays low until the fifo drains, whatever the trigger
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rx_rdy_n_reg <= 1'b1;
        end else if (ce) begin
            if (dma1) begin
                if (rx_empty) begin
                    rx_rdy_n_reg <= 1'b1;
                end else if (rx_level >= rx_trg || to_pend_reg) begin
                    rx_rdy_n_reg <= 1'b0;
                end
            end else begin
                rx_rdy_n_reg <= rx_empty;
            end
        end
    end

    // Outputs straight from flops
    assign wb_ack_o       = ack_reg;
    assign wb_dat_o       = dat_reg;
    assign tx_dma_ready_n = tx_rdy_n_reg;
    assign rx_dma_ready_n = rx_rdy_n_reg;
    assign fifo_en_o      = fifo_control_reg[UFIS_FCR_EN];
    assign tx_flush_o     = tx_flush_reg;
    assign rx_flush_o     = rx_flush_reg;

endmodule

// ---- ufis_pkg.sv ----
package ufis_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [4:0] UFIS_OFS_FCR   = 5'h00;
    localparam logic [4:0] UFIS_OFS_ISR   = 5'h04;
    localparam logic [4:0] UFIS_OFS_IEN   = 5'h08;
    localparam logic [4:0] UFIS_OFS_EFR   = 5'h0C;
    localparam logic [4:0] UFIS_OFS_LVL   = 5'h10;

    // Fifo control field positions
    localparam int UFIS_FCR_EN       = 0;
    localparam int UFIS_FCR_RXFLUSH  = 1;
    localparam int UFIS_FCR_TXFLUSH  = 2;
    localparam int UFIS_FCR_DMA      = 3;
    localparam int UFIS_FCR_TXTRG_LO = 4;
    localparam int UFIS_FCR_RXTRG_LO = 6;

    // Interrupt enable field positions
    localparam int UFIS_IEN_RXDATA = 0;
    localparam int UFIS_IEN_THRE   = 1;
    localparam int UFIS_IEN_LINE   = 2;
    localparam int UFIS_IEN_MODEM  = 3;
    localparam int UFIS_IEN_XOFF   = 4;
    localparam int UFIS_IEN_FLOW   = 5;

    // Enhanced feature enable bit
    localparam int UFIS_EFR_ENH = 4;

    // Reset values
    localparam logic [7:0] UFIS_FCR_RST = 8'h00;
    localparam logic [5:0] UFIS_IEN_RST = 6'h00;
    localparam logic [7:0] UFIS_EFR_RST = 8'h00;

    // Default fifo depth in bytes
    localparam int UFIS_DEPTH = 32;

    // Trigger levels in bytes
    localparam int UFIS_RXTRG_0 = 8;
    localparam int UFIS_RXTRG_1 = 16;
    localparam int UFIS_RXTRG_2 = 24;
    localparam int UFIS_RXTRG_3 = 28;
    localparam int UFIS_TXTRG_0 = 16;
    localparam int UFIS_TXTRG_1 = 8;
    localparam int UFIS_TXTRG_2 = 24;
    localparam int UFIS_TXTRG_3 = 30;

    // Status codes, bits 5:0
    localparam logic [5:0] UFIS_ISR_NONE  = 6'h01;
    localparam logic [5:0] UFIS_ISR_LINE  = 6'h06;
    localparam logic [5:0] UFIS_ISR_RXDAT = 6'h04;
    localparam logic [5:0] UFIS_ISR_RXTO  = 6'h0C;
    localparam logic [5:0] UFIS_ISR_THRE  = 6'h02;
    localparam logic [5:0] UFIS_ISR_MODEM = 6'h00;
    localparam logic [5:0] UFIS_ISR_XOFF  = 6'h10;
    localparam logic [5:0] UFIS_ISR_FLOW  = 6'h20;

    // Events from the surrounding UART logic, one-cycle pulses on mclk
    typedef struct packed {
        logic rx_push;     // Receive shifter delivers a byte
        logic rx_pop;      // Host reads receive holding
        logic tx_push;     // Host writes tx_holding_reg
        logic tx_pop;      // Transmit shifter takes a byte
        logic line_evt;    // Receiver line status error
        logic line_clr;    // Host read of line_status_reg
        logic timeout_evt; // Receive character timeout
        logic modem_evt;   // Modem input change
        logic modem_clr;   // Host read of modem_status_reg
        logic xoff_evt;    // Matching Xoff or special character
        logic xon_evt;     // Matching Xon received
        logic flow_evt;    // CTS or RTS state change
    } ufis_evt_t;

endpackage

// ---- ufis_fifo_level.sv ----
`timescale 1ns/100ps
module ufis_fifo_level
    import ufis_pkg::*;
#(
    parameter int DEPTH = UFIS_DEPTH,
    parameter int LW    = $clog2(DEPTH + 1)
) (
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    input  wire logic          flush,
    input  wire logic          single,
    input  wire logic          push,
    input  wire logic          pop,
    output logic [LW-1:0]      level,
    output logic               full,
    output logic               empty
);

    // The counter must be able to hold a full fifo
    if (LW < $clog2(DEPTH + 1)) begin : g_lw_chk
        $error("ufis_fifo_level: LW too narrow for DEPTH");
    end

    logic [LW-1:0] level_reg;  // Bytes held
    logic [LW-1:0] cap;        // One byte in holding-register mode
    logic          do_push;
    logic          do_pop;

    // Capacity shrinks to a single holding register without fifos
    assign cap     = single ? LW'(1) : LW'(DEPTH);
    assign full    = (level_reg >= cap);
    assign empty   = (level_reg == '0);
    assign level   = level_reg;
    // Overflowing pushes and underflowing pops are dropped
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;

    // Occupancy counter; flush only touches the count, never a shifter
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            level_reg <= '0;
        end else if (ce) begin
            if (flush) begin
                level_reg <= '0;
            end else if (do_push && !do_pop) begin
                level_reg <= level_reg + LW'(1);
            end else if (do_pop && !do_push) begin
                level_reg <= level_reg - LW'(1);
            end
        end
    end

endmodule

// ---- ufis_top_asserts.sv ----
`timescale 1ns/100ps
// Watches the bus and control outputs of ufis_top
module ufis_top_chk #(
    parameter int DEPTH = 32
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        fifo_en_o,
    input  wire logic        tx_flush_o,
    input  wire logic        rx_flush_o
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Request taken by the slave
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
    endsequence
    // Accepted control write, byte lane 0 enabled
    sequence s_fcr_wr;
        s_take ##0 (wb_we_i && wb_adr_i == 5'h00 && wb_sel_i[0]);
    endsequence
    // Status read
    sequence s_isr_rd;
        s_take ##0 (!wb_we_i && wb_adr_i == 5'h04);
    endsequence
    property p_ack_resp;
        s_take |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
    property p_ack_pulse;
        wb_ack_o && ce |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_rst_en;
        $rose(rst_n) |-> !fifo_en_o;
    endproperty
    a_rst_en: assert property (p_rst_en) else $error("fifo enable set after reset");
    property p_en_wr;
        s_fcr_wr |=> fifo_en_o == $past(wb_dat_i[0]);
    endproperty
    a_en_wr: assert property (p_en_wr) else $error("fifo enable not written");
    property p_txflush;
        s_fcr_wr ##0 (wb_dat_i[0] && wb_dat_i[2] && fifo_en_o) |-> ##[1:2] tx_flush_o;
    endproperty
    a_txflush: assert property (p_txflush) else $error("tx flush missing");
    property p_rxflush;
        s_fcr_wr ##0 (wb_dat_i[0] && wb_dat_i[1] && fifo_en_o) |-> ##[1:2] rx_flush_o;
    endproperty
    a_rxflush: assert property (p_rxflush) else $error("rx flush missing");
    property p_flush_once;
        tx_flush_o || rx_flush_o |=> !tx_flush_o && !rx_flush_o;
    endproperty
    a_flush_once: assert property (p_flush_once) else $error("flush not cleared");
    property p_isr_top;
        s_isr_rd |=> wb_dat_o[7:6] == {2{fifo_en_o}} && wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_isr_top: assert property (p_isr_top) else $error("status top bits wrong");
    property p_isr_b0;
        s_isr_rd |=> wb_dat_o[0] == (wb_dat_o[5:0] == 6'h01);
    endproperty
    a_isr_b0: assert property (p_isr_b0) else $error("pending bit wrong");
    property p_ce_hold;
        !ce |=> $stable(fifo_en_o) && $stable(wb_ack_o) && $stable(wb_dat_o);
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("state moved with enable low");
endmodule
bind ufis_top ufis_top_chk #(.DEPTH(DEPTH)) i_chk (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fifo_en_o(fifo_en_o),
    .tx_flush_o(tx_flush_o), .rx_flush_o(rx_flush_o));

// ---- ufis_host.sv ----
`timescale 1ns/100ps
// Host processor model: Wishbone classic master
module ufis_host (
    input  wire logic        mclk,
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic [4:0]       adr,
    output logic [3:0]       sel,
    output logic [31:0]      dat,
    input  wire logic        ack,
    input  wire logic [31:0] din
);
    // Idle bus from time zero
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 5'h00;
        sel = 4'h0;
        dat = 32'h0;
    end
    // One cycle; callers also program control with the enable bit clear
    task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d,
                        output logic [31:0] q);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= {24'h000000, d};
        // Hold until ack is sampled; only the bench watchdog ends a hang
        do
            @(posedge mclk);
        while (ack !== 1'b1);
        q = din;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        // Released lines must not keep the old value
        adr <= ~a;
        dat <= ~dat;
    endtask
endmodule

// ---- ufis_top_tb.sv ----
`timescale 1ns/100ps
module ufis_top_tb;
    import ufis_pkg::*;
    localparam int RXP = 11, RXO = 10, TXP = 9, TXO = 8, LNE = 7, LNC = 6;
    localparam int TMO = 5, MDE = 4, MDC = 3, XOF = 2, XON = 1, FLW = 0;
    logic        mclk;
    logic        rst_n;
    logic        ce;        // Clock enable, low freezes the block
    logic [11:0] ev;        // Event pulses, rx_push on top
    logic        cyc, stb, we, ack, fen, txr_n, rxr_n;
    logic [4:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, din, rv;
    int          bad_count;
    int          tests_run;
    int          rxt[4] = '{UFIS_RXTRG_0, UFIS_RXTRG_1, UFIS_RXTRG_2, UFIS_RXTRG_3};
    int          txt[4] = '{UFIS_TXTRG_0, UFIS_TXTRG_1, UFIS_TXTRG_2, UFIS_TXTRG_3};

    ufis_host i_host (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
                      .dat(dat), .ack(ack), .din(din));
    ufis_top i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(din),
        .wb_ack_o(ack), .evt(ufis_evt_t'(ev)), .tx_dma_ready_n(txr_n),
        .rx_dma_ready_n(rxr_n), .fifo_en_o(fen), .tx_flush_o(), .rx_flush_o());

    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", nm, e, s);
        end
    endtask

    task summarize;
        if (bad_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task wr(input logic [4:0] a, input logic [7:0] d);
        i_host.xfer(1'b1, a, d, rv);
    endtask

    // Read status and compare
    task ick(input logic [31:0] e);
        i_host.xfer(1'b0, UFIS_OFS_ISR, 8'h00, rv);
        chk("isr", rv, e);
    endtask

    // n single-cycle pulses on one event bit
    task pz(input int b, input int n);
        repeat (n) begin
            @(posedge mclk);
            ev <= 12'h001 << b;
            @(posedge mclk);
            ev <= 12'h000;
        end
    endtask

    // Counts land, then registered pins follow
    task settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task t_reset;
        ick(32'h00000001);
        chk("fifo_en", fen, 32'h0);
        i_host.xfer(1'b0, 5'h14, 8'h00, rv);
        chk("unmapped", rv, 32'h0);
        wr(UFIS_OFS_FCR, 8'h0E);
        settle;
        chk("fifo_en", fen, 32'h0);
        wr(UFIS_OFS_FCR, 8'h01);
        chk("fifo_en", fen, 32'h1);
        ick(32'h000000C1);
        wr(UFIS_OFS_IEN, 8'h01);
    endtask

    // Every trigger code in block DMA mode
    task t_trig;
        logic [1:0] k;
        for (int c = 0; c < 4; c++) begin
            k = c[1:0];
            wr(UFIS_OFS_FCR, {k, k, 4'hF});
            pz(RXP, rxt[c] - 1);
            settle;
            chk("rx_rdy", rxr_n, 32'h1);
            pz(RXP, 1);
            settle;
            chk("rx_rdy", rxr_n, 32'h0);
            ick(32'h000000C4);
            pz(RXO, 1);
            settle;
            chk("rx_rdy", rxr_n, 32'h0);
            ick(32'h000000C1);
            pz(TXP, 32);
            settle;
            chk("tx_rdy", txr_n, 32'h1);
            pz(TXO, 31 - txt[c]);
            settle;
            chk("tx_rdy", txr_n, 32'h1);
            pz(TXO, 1);
            settle;
            chk("tx_rdy", txr_n, 32'h0);
            wr(UFIS_OFS_FCR, {k, k, 4'hF});
            settle;
            i_host.xfer(1'b0, UFIS_OFS_LVL, 8'h00, rv);
            chk("levels", rv & 32'h00033F3F, 32'h00020000);
        end
    endtask

    // All six levels pending, serviced from the top
    task t_prio;
        wr(UFIS_OFS_FCR, 8'h09);
        wr(UFIS_OFS_EFR, 8'h10);
        wr(UFIS_OFS_IEN, 8'h3F);
        pz(RXP, 1);
        pz(TMO, 1);
        pz(LNE, 1);
        pz(MDE, 1);
        pz(XOF, 1);
        pz(FLW, 1);
        settle;
        chk("rx_rdy", rxr_n, 32'h0);
        ick(32'h000000C6);
        pz(LNC, 1);
        settle;
        ick(32'h000000CC);
        pz(RXO, 1);
        settle;
        ick(32'h000000C2);
        ick(32'h000000C0);
        pz(MDC, 1);
        settle;
        ick(32'h000000D0);
        ick(32'h000000D0);
        wr(UFIS_OFS_EFR, 8'h00);
        ick(32'h000000C1);
        wr(UFIS_OFS_EFR, 8'h10);
        pz(XON, 1);
        settle;
        ick(32'h000000E0);
        ick(32'h000000C1);
    endtask

    // Single-transfer mode, clock-enable freeze, then fifos off
    task t_mode;
        wr(UFIS_OFS_FCR, 8'h01);
        pz(TXP, 1);
        settle;
        chk("tx_rdy", txr_n, 32'h1);
        @(posedge mclk);
        ce <= 1'b0;
        pz(TXO, 1);
        ce <= 1'b1;
        settle;
        i_host.xfer(1'b0, UFIS_OFS_LVL, 8'h00, rv);
        chk("frozen", rv & 32'h00013F3F, 32'h00010100);
        pz(TXO, 1);
        settle;
        chk("tx_rdy", txr_n, 32'h0);
        wr(UFIS_OFS_FCR, 8'h00);
        pz(RXP, 2);
        settle;
        chk("rx_rdy", rxr_n, 32'h0);
        ick(32'h00000004);
        i_host.xfer(1'b0, UFIS_OFS_LVL, 8'h00, rv);
        chk("levels", rv & 32'h00023F3F, 32'h00000001);
    endtask

    // Main sequence
    initial begin
        bad_count = 0;
        tests_run = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        ev = 12'h000;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset;
        t_trig;
        t_prio;
        t_mode;
        summarize;
    end

    // Watchdog, far beyond the several hundred cycles expected
    initial begin
        #400000;
        bad_count++;
        summarize;
    end
endmodule
